// *** dasf_flags.sv ***
`timescale 1ns/100ps
// Function
// (R1) unused upper bits always read zero
// (R2) alarm bit 8 shows encoder fault
// (R3) alarm bit 7 shows tracking error
// (R4) alarm bit 6 shows phase loss
// (R5) alarm bit 5 shows parameter check failure
// (R6) alarm bit 4 shows over temperature
// (R7) alarm bit 3 shows under voltage
// (R8) alarm bit 2 shows over voltage
// (R9) alarm bit 1 shows over current
// (R10) alarm bit 0 shows internal supply error
// (R11) state bit 10 shows power present
// (R12) state bit 9 shows negative limit
// (R13) state bit 8 shows positive limit
// (R14) state bit 7 shows brake released
// (R15) bit 6 speed reached in pulse mode
// (R16) ready low 100ms after enable rise
// (R17) ready low during power-on self test
// (R18) state bit 4 shows homing done
// (R19) running bit; only stop accepted while running
// (R20) bit 2 positioning done in closed loop
// (R21) bit 1 set whenever any alarm present
// (R22) bit 0 enabled, enabled after reset
module dasf_flags #(
  parameter int READY_CYCLES = dasf_pkg::READY_DELAY_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // raw conditions from the drive, asynchronous
  input wire dasf_pkg::dasf_alarm_t alarmIn,
  input wire dasf_pkg::dasf_state_t stateIn,
  // enable request level from the drive controller
  input wire logic enableReq,
  // motion commands, same clock domain
  input wire dasf_pkg::dasf_cmd_t cmdIn,
  // register read port
  input wire logic rdStrobe,
  input wire logic [15:0] rdAddr,
  output logic [15:0] rdData,
  output logic rdValid,
  // accepted commands towards the motion engine
  output logic moveAccepted,
  output logic stopAccepted
);

  localparam int AW = $bits(dasf_pkg::dasf_alarm_t);
  localparam int SW = $bits(dasf_pkg::dasf_state_t);

  initial begin
    if (READY_CYCLES < 1) begin
      $error("ready cycles must be positive");
    end
  end

  // two-stage synchronisers for every asynchronous condition
  logic [AW-1:0] alarmMeta_reg;
  logic [AW-1:0] alarmSync_reg;
  logic [SW-1:0] stateMeta_reg;
  logic [SW-1:0] stateSync_reg;
  logic enMeta_reg;
  logic enSync_reg;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      alarmMeta_reg <= '0;
      alarmSync_reg <= '0;
      stateMeta_reg <= '0;
      stateSync_reg <= '0;
      enMeta_reg <= dasf_pkg::DRIVE_ENABLED_RESET;
      enSync_reg <= dasf_pkg::DRIVE_ENABLED_RESET;
    end else begin
      alarmMeta_reg <= alarmIn;
      alarmSync_reg <= alarmMeta_reg;
      stateMeta_reg <= stateIn;
      stateSync_reg <= stateMeta_reg;
      enMeta_reg <= enableReq;
      enSync_reg <= enMeta_reg;
    end
  end

  dasf_pkg::dasf_alarm_t alarm_summary;
  dasf_pkg::dasf_state_t st;
  assign alarm_summary = alarmSync_reg;
  assign st = stateSync_reg;

  // ready timer runs from the synchronised enable
  logic readyNow;

  // (R16) settle after enable
  // (R17) held during self test
  dasf_ready_timer #(
    .DELAY_CYCLES(READY_CYCLES)
  ) u_ready (
    .clk(clk),
    .sys_rst(sys_rst),
    .enabled(enSync_reg),
    .holdOff(st.selfTestBusy),
    .ready(readyNow)
  );

  // image registers, one per flag word
  logic [15:0] alarmImg_reg;
  logic [15:0] alarmImg_next;
  logic [15:0] stateImg_reg;
  logic [15:0] stateImg_next;

  // assemble both images from the synchronised conditions
  always_comb begin
    // (R1) zero upper bits
    alarmImg_next = 16'h0000;
    stateImg_next = 16'h0000;
    // (R2) encoder fault bit
    alarmImg_next[dasf_pkg::ALM_ENCODER_BIT] = alarm_summary.encoderFault;
    // (R3) tracking error bit
    alarmImg_next[dasf_pkg::ALM_TRACKING_BIT] = alarm_summary.trackingError;
    // (R4) phase loss bit
    alarmImg_next[dasf_pkg::ALM_PHASE_LOSS_BIT] = alarm_summary.phaseLoss;
    // (R5) parameter check bit
    alarmImg_next[dasf_pkg::ALM_PARAM_CHECK_BIT] = alarm_summary.paramCheckError;
    // (R6) over temperature bit
    alarmImg_next[dasf_pkg::ALM_OVER_TEMP_BIT] = alarm_summary.overTemperature;
    // (R7) under voltage bit
    alarmImg_next[dasf_pkg::ALM_UNDER_VOLTAGE_BIT] = alarm_summary.underVoltage;
    // (R8) over voltage bit
    alarmImg_next[dasf_pkg::ALM_OVER_VOLTAGE_BIT] = alarm_summary.overVoltage;
    // (R9) over current bit
    alarmImg_next[dasf_pkg::ALM_OVER_CURRENT_BIT] = alarm_summary.overCurrent;
    // (R10) internal supply bit
    alarmImg_next[dasf_pkg::ALM_INTERNAL_SUPPLY_BIT] = alarm_summary.internalSupplyError;
    // (R11) power present bit
    stateImg_next[dasf_pkg::ST_POWER_BIT] = st.powerPresent;
    // (R12) negative limit bit
    stateImg_next[dasf_pkg::ST_NEG_LIMIT_BIT] = st.negLimitActive;
    // (R13) positive limit bit
    stateImg_next[dasf_pkg::ST_POS_LIMIT_BIT] = st.posLimitActive;
    // (R14) brake released bit
    stateImg_next[dasf_pkg::ST_BRAKE_BIT] = st.brakeReleased;
    // (R15) speed only in pulse mode
    stateImg_next[dasf_pkg::ST_SPEED_BIT] = st.pulseCmdMode & st.speedReached;
    // (R16) ready bit from timer
    stateImg_next[dasf_pkg::ST_READY_BIT] = readyNow;
    // (R18) homing done bit
    stateImg_next[dasf_pkg::ST_HOMED_BIT] = st.homingDone;
    // (R19) running bit
    stateImg_next[dasf_pkg::ST_RUNNING_BIT] = st.motorRunning;
    // (R20) in position, closed loop
    stateImg_next[dasf_pkg::ST_POSITION_BIT] = st.closedLoopMode & st.positionReached;
    // (R21) summary of all alarms
    stateImg_next[dasf_pkg::ST_ALARM_BIT] = |alarmImg_next[dasf_pkg::ALM_USED_BITS-1:0];
    // (R22) enabled bit
    stateImg_next[dasf_pkg::ST_ENABLED_BIT] = enSync_reg;
  end

  // image registers; reset values as documented
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      alarmImg_reg <= dasf_pkg::ALARM_FLAGS_RESET;
      stateImg_reg <= dasf_pkg::DRIVE_STATE_FLAGS_RESET;
    end else begin
      alarmImg_reg <= alarmImg_next;
      stateImg_reg <= stateImg_next;
    end
  end

  // read port and command gating
  logic [15:0] rdData_reg;
  logic [15:0] rdData_next;
  logic rdValid_reg;
  logic rdValid_next;
  logic moveAcc_reg;
  logic moveAcc_next;
  logic stopAcc_reg;
  logic stopAcc_next;

  // one-cycle read answer; unmapped addresses read zero
  always_comb begin
    rdValid_next = rdStrobe;
    rdData_next = 16'h0000;
    if (rdStrobe) begin
      unique case (rdAddr)
        dasf_pkg::ALARM_FLAGS_ADDR: begin
          rdData_next = alarmImg_reg;
        end
        dasf_pkg::DRIVE_STATE_FLAGS_ADDR: begin
          rdData_next = stateImg_reg;
        end
        default: begin
          rdData_next = 16'h0000;
        end
      endcase
    end
    // (R19) refuse moves while running
    moveAcc_next = cmdIn.startMove & ~cmdIn.stopMove
      & ~stateImg_reg[dasf_pkg::ST_RUNNING_BIT];
    // stop always passes, and wins over a simultaneous move
    stopAcc_next = cmdIn.stopMove;
  end

  // read and command registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdData_reg <= 16'h0000;
      rdValid_reg <= 1'b0;
      moveAcc_reg <= 1'b0;
      stopAcc_reg <= 1'b0;
    end else begin
      rdData_reg <= rdData_next;
      rdValid_reg <= rdValid_next;
      moveAcc_reg <= moveAcc_next;
      stopAcc_reg <= stopAcc_next;
    end
  end

  assign rdData = rdData_reg;
  assign rdValid = rdValid_reg;
  assign moveAccepted = moveAcc_reg;
  assign stopAccepted = stopAcc_reg;

  // checks next to the logic

  a_upper_zero: assert property (@(posedge clk) disable iff (sys_rst) // (R1)
    (alarmImg_reg[15:9] == 7'h0) && (stateImg_reg[15:11] == 5'h0))
    else $error("reserved flag bits not zero");

  a_alarm_summary: assert property (@(posedge clk) disable iff (sys_rst) // (R21)
    stateImg_reg[dasf_pkg::ST_ALARM_BIT] == (|alarmImg_reg))
    else $error("alarm summary disagrees with alarm word");

  a_encoder_path: assert property (@(posedge clk) disable iff (sys_rst) // (R2)
    alarmSync_reg[AW-1] |=> alarmImg_reg[dasf_pkg::ALM_ENCODER_BIT])
    else $error("encoder fault not reflected");

  a_ready_needs_en: assert property (@(posedge clk) disable iff (sys_rst) // (R16)
    !enSync_reg |=> ##1 !stateImg_reg[dasf_pkg::ST_READY_BIT] [*2])
    else $error("ready while disabled");

  a_ready_selftest: assert property (@(posedge clk) disable iff (sys_rst) // (R17)
    st.selfTestBusy |=> ##1 !stateImg_reg[dasf_pkg::ST_READY_BIT])
    else $error("ready during self test");

  a_move_refused: assert property (@(posedge clk) disable iff (sys_rst) // (R19)
    stateImg_reg[dasf_pkg::ST_RUNNING_BIT] |=> !moveAcc_reg)
    else $error("move accepted while running");

  a_stop_passes: assert property (@(posedge clk) disable iff (sys_rst) // (R19)
    cmdIn.stopMove |=> stopAcc_reg)
    else $error("stop command lost");

  a_speed_mode: assert property (@(posedge clk) disable iff (sys_rst) // (R15)
    !$past(st.pulseCmdMode) |-> !stateImg_reg[dasf_pkg::ST_SPEED_BIT])
    else $error("speed reached outside pulse mode");

  a_position_reached_mode: assert property (@(posedge clk) disable iff (sys_rst) // (R20)
    !$past(st.closedLoopMode) |-> !stateImg_reg[dasf_pkg::ST_POSITION_BIT])
    else $error("in position outside closed loop");

  a_enable_bit: assert property (@(posedge clk) disable iff (sys_rst) // (R22)
    $rose(enSync_reg) |=> stateImg_reg[dasf_pkg::ST_ENABLED_BIT])
    else $error("enabled bit not following enable");

  a_read_answer: assert property (@(posedge clk) disable iff (sys_rst) // (R1)
    (rdStrobe && rdAddr > 16'h0001) |=> (rdValid_reg && rdData_reg == 16'h0000))
    else $error("unmapped read not zero");

  a_read_alarm: assert property (@(posedge clk) disable iff (sys_rst) // (R21)
    (rdStrobe && rdAddr == dasf_pkg::ALARM_FLAGS_ADDR)
      |=> rdData_reg == $past(alarmImg_reg))
    else $error("alarm word read wrong");

  a_read_state: assert property (@(posedge clk) disable iff (sys_rst) // (R22)
    (rdStrobe && rdAddr == dasf_pkg::DRIVE_STATE_FLAGS_ADDR)
      |=> rdData_reg == $past(stateImg_reg))
    else $error("state word read wrong");

  a_power_path: assert property (@(posedge clk) disable iff (sys_rst) // (R11)
    st.powerPresent |=> stateImg_reg[dasf_pkg::ST_POWER_BIT])
    else $error("power present not reflected");

  a_neg_limit: assert property (@(posedge clk) disable iff (sys_rst) // (R12)
    st.negLimitActive |=> stateImg_reg[dasf_pkg::ST_NEG_LIMIT_BIT])
    else $error("negative limit not reflected");

  a_enable_low: assert property (@(posedge clk) disable iff (sys_rst) // (R22)
    !enSync_reg |=> !stateImg_reg[dasf_pkg::ST_ENABLED_BIT])
    else $error("enabled bit set while disabled");

  // helper: length of the current enabled stretch free of self test;
  // kept apart from the timer so the ready check does not lean on it
  logic [31:0] enRun_reg;
  logic [31:0] enRun_next;

  // (R16) enabled stretch count
  // saturates so a long enabled run never wraps back to zero
  always_comb begin
    enRun_next = enRun_reg;
    if (!enSync_reg || st.selfTestBusy) begin
      enRun_next = 32'h0000_0000;
    end else if (enRun_reg != 32'hFFFF_FFFF) begin
      enRun_next = enRun_reg + 32'h0000_0001;
    end
  end

  // helper register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      enRun_reg <= 32'h0000_0000;
    end else begin
      enRun_reg <= enRun_next;
    end
  end

  a_ready_settled: assert property (@(posedge clk) disable iff (sys_rst) // (R16)
    $rose(stateImg_reg[dasf_pkg::ST_READY_BIT]) |-> enRun_reg >= 32'(READY_CYCLES))
    else $error("ready before settling time");

endmodule : dasf_flags

// *** dasf_pkg.sv ***
package dasf_pkg;

  // register indices on the modbus register space
  localparam logic [15:0] ALARM_FLAGS_ADDR = 16'h0000;
  localparam logic [15:0] DRIVE_STATE_FLAGS_ADDR = 16'h0001;

  // alarm register bit positions
  localparam int ALM_INTERNAL_SUPPLY_BIT = 0;
  localparam int ALM_OVER_CURRENT_BIT = 1;
  localparam int ALM_OVER_VOLTAGE_BIT = 2;
  localparam int ALM_UNDER_VOLTAGE_BIT = 3;
  localparam int ALM_OVER_TEMP_BIT = 4;
  localparam int ALM_PARAM_CHECK_BIT = 5;
  localparam int ALM_PHASE_LOSS_BIT = 6;
  localparam int ALM_TRACKING_BIT = 7;
  localparam int ALM_ENCODER_BIT = 8;
  localparam int ALM_USED_BITS = 9;

  // state register bit positions
  localparam int ST_ENABLED_BIT = 0;
  localparam int ST_ALARM_BIT = 1;
  localparam int ST_POSITION_BIT = 2;
  localparam int ST_RUNNING_BIT = 3;
  localparam int ST_HOMED_BIT = 4;
  localparam int ST_READY_BIT = 5;
  localparam int ST_SPEED_BIT = 6;
  localparam int ST_BRAKE_BIT = 7;
  localparam int ST_POS_LIMIT_BIT = 8;
  localparam int ST_NEG_LIMIT_BIT = 9;
  localparam int ST_POWER_BIT = 10;
  localparam int ST_USED_BITS = 11;

  // reset values of both registers
  localparam logic [15:0] ALARM_FLAGS_RESET = 16'h0000;
  localparam logic [15:0] DRIVE_STATE_FLAGS_RESET = 16'h0011;
  localparam logic DRIVE_ENABLED_RESET = 1'b1;

  // ready settling time after enable
  localparam int READY_DELAY_MS = 100;
  localparam int CLK_HZ = 25_000_000;
  localparam int READY_DELAY_CYCLES = READY_DELAY_MS * (CLK_HZ / 1000);

  // raw alarm conditions from the detectors
  typedef struct packed {
    logic encoderFault;
    logic trackingError;
    logic phaseLoss;
    logic paramCheckError;
    logic overTemperature;
    logic underVoltage;
    logic overVoltage;
    logic overCurrent;
    logic internalSupplyError;
  } dasf_alarm_t;

  // raw drive state conditions
  typedef struct packed {
    logic powerPresent;
    logic negLimitActive;
    logic posLimitActive;
    logic brakeReleased;
    logic speedReached;
    logic homingDone;
    logic motorRunning;
    logic positionReached;
    logic pulseCmdMode;
    logic closedLoopMode;
    logic selfTestBusy;
  } dasf_state_t;

  // motion command strobes
  typedef struct packed {
    logic startMove;
    logic stopMove;
  } dasf_cmd_t;

endpackage : dasf_pkg

// *** dasf_ready_timer.sv ***
`timescale 1ns/100ps
// counts the ready settling time after each enable rising edge
module dasf_ready_timer #(
  parameter int DELAY_CYCLES = dasf_pkg::READY_DELAY_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // control
  input wire logic enabled,
  input wire logic holdOff,
  // result
  output logic ready
);

  localparam int CW = $clog2(DELAY_CYCLES + 1);

  initial begin
    if (DELAY_CYCLES < 1) begin
      $error("ready delay must be at least one cycle");
    end
  end

  logic [CW-1:0] count_reg;
  logic [CW-1:0] count_next;
  logic ready_reg;
  logic ready_next;

  // restart on disable or self test, count up to the settling time
  always_comb begin
    count_next = count_reg;
    ready_next = ready_reg;
    if (!enabled || holdOff) begin
      count_next = '0;
      ready_next = 1'b0;
    end else if (count_reg == CW'(DELAY_CYCLES)) begin
      ready_next = 1'b1;
    end else begin
      count_next = count_reg + CW'(1);
    end
  end

  // counter registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_reg <= '0;
      ready_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      ready_reg <= ready_next;
    end
  end

  assign ready = ready_reg;

endmodule : dasf_ready_timer

// *** dasf_reg_master.sv ***
`timescale 1ns/100ps
// register master model on the far side of the read port
module dasf_reg_master (
  // clock
  input wire logic clk,
  // read port towards the flag block
  output logic rdStrobe,
  output logic [15:0] rdAddr,
  input wire logic [15:0] rdData,
  input wire logic rdValid
);
  // idle port, address holds a pattern
  initial begin
    rdStrobe = 1'b0;
    rdAddr = 16'h5555;
  end

  // one read: request at a falling edge, answer taken one cycle later
  task automatic read(input logic [15:0] addr, output logic [15:0] data, output logic valid);
    @(negedge clk);
    rdStrobe = 1'b1;
    rdAddr = addr;
    @(negedge clk);
    data = rdData;
    valid = rdValid;
    rdStrobe = 1'b0;
    // released address inverted so a stale address never passes
    rdAddr = ~addr;
  endtask : read
endmodule : dasf_reg_master

// *** tb_drive_alarm_status_flags.sv ***
`timescale 1ns/100ps
// self-checking bench for the two drive flag registers
module tb_drive_alarm_status_flags;
  // short ready delay keeps the run brief
  localparam int ReadyCycles = 20;
  // stimulus and observed signals
  logic clk;
  logic sys_rst;
  dasf_pkg::dasf_alarm_t alarmIn;
  dasf_pkg::dasf_state_t stateIn;
  logic enableReq;
  dasf_pkg::dasf_cmd_t cmdIn;
  logic rdStrobe;
  logic [15:0] rdAddr;
  logic [15:0] rdData;
  logic rdValid;
  logic moveAccepted;
  logic stopAccepted;
  int miscompares;
  int checked;
  // state input patterns and the state image each should give
  logic [10:0] stVec [11] = '{11'h400, 11'h200, 11'h100, 11'h080, 11'h040, 11'h044,
                              11'h020, 11'h010, 11'h008, 11'h00A, 11'h001};
  logic [15:0] stExp [11] = '{16'h0421, 16'h0221, 16'h0121, 16'h00A1, 16'h0021, 16'h0061,
                              16'h0031, 16'h0029, 16'h0021, 16'h0025, 16'h0001};

  // design under test
  dasf_flags #(.READY_CYCLES(ReadyCycles)) u_dasf_flags (
    .clk(clk), .sys_rst(sys_rst), .alarmIn(alarmIn), .stateIn(stateIn),
    .enableReq(enableReq), .cmdIn(cmdIn), .rdStrobe(rdStrobe), .rdAddr(rdAddr),
    .rdData(rdData), .rdValid(rdValid), .moveAccepted(moveAccepted),
    .stopAccepted(stopAccepted)
  );

  // far side master
  dasf_reg_master u_dasf_reg_master (
    .clk(clk), .rdStrobe(rdStrobe), .rdAddr(rdAddr), .rdData(rdData), .rdValid(rdValid)
  );

  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // compare and count
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (e !== g) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // read one register and check valid and data
  task automatic rd(input logic [15:0] a, input logic [15:0] e, input string n);
    logic [15:0] d;
    logic v;
    u_dasf_reg_master.read(a, d, v);
    chk("read valid", 16'h0001, {15'h0000, v});
    chk(n, e, d);
  endtask : rd

  // apply conditions and wait out sync plus image latency
  task automatic settle(input logic [8:0] a, input logic [10:0] s);
    @(negedge clk);
    alarmIn = dasf_pkg::dasf_alarm_t'(a);
    stateIn = dasf_pkg::dasf_state_t'(s);
    repeat (4) @(negedge clk);
  endtask : settle

  // one-cycle command pulse, acceptance seen one cycle later
  task automatic cmd(input logic [1:0] c, input logic expMove, input logic expStop);
    @(negedge clk);
    cmdIn = dasf_pkg::dasf_cmd_t'(c);
    @(negedge clk);
    cmdIn = '0;
    chk("move accepted", {15'h0000, expMove}, {15'h0000, moveAccepted});
    chk("stop accepted", {15'h0000, expStop}, {15'h0000, stopAccepted});
  endtask : cmd

  // verdict and end of run
  task automatic results();
    $display("counts: checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : results

  // watchdog, run needs well under a thousand cycles
  initial begin
    repeat (4000) @(posedge clk);
    miscompares++;
    results();
  end

  // main sequence
  initial begin
    sys_rst = 1'b1;
    alarmIn = '0;
    stateIn = '0;
    enableReq = 1'b1;
    cmdIn = '0;
    miscompares = 0;
    checked = 0;
    repeat (20) @(negedge clk);
    sys_rst = 1'b0;
    rd(dasf_pkg::DRIVE_STATE_FLAGS_ADDR, 16'h0001, "state after reset");
    repeat (ReadyCycles + 10) @(negedge clk);
    rd(dasf_pkg::DRIVE_STATE_FLAGS_ADDR, 16'h0021, "state ready");
    // walk one alarm at a time, summary bit follows
    for (int i = 0; i < 9; i++) begin
      settle(9'h001 << i, 11'h000);
      rd(dasf_pkg::DRIVE_STATE_FLAGS_ADDR, 16'h0023, "alarm summary");
      rd(dasf_pkg::ALARM_FLAGS_ADDR, 16'h0001 << i, "alarm bit");
    end
    settle(9'h1FF, 11'h000);
    rd(dasf_pkg::ALARM_FLAGS_ADDR, 16'h01FF, "all alarms");
    // each state condition, modes gating speed and in-position
    for (int i = 0; i < 11; i++) begin
      settle(9'h000, stVec[i]);
      rd(dasf_pkg::DRIVE_STATE_FLAGS_ADDR, stExp[i], "state bit");
    end
    settle(9'h000, 11'h000);
    repeat (ReadyCycles + 10) @(negedge clk);
    rd(dasf_pkg::DRIVE_STATE_FLAGS_ADDR, 16'h0021, "ready after test");
    // commands while stopped, then while running
    cmd(2'b10, 1'b1, 1'b0);
    cmd(2'b01, 1'b0, 1'b1);
    cmd(2'b11, 1'b0, 1'b1);
    settle(9'h000, 11'h010);
    cmd(2'b10, 1'b0, 1'b0);
    cmd(2'b01, 1'b0, 1'b1);
    // disable then enable again, ready waits its delay
    enableReq = 1'b0;
    settle(9'h000, 11'h000);
    rd(dasf_pkg::DRIVE_STATE_FLAGS_ADDR, 16'h0000, "disabled");
    enableReq = 1'b1;
    settle(9'h000, 11'h000);
    rd(dasf_pkg::DRIVE_STATE_FLAGS_ADDR, 16'h0001, "enable early");
    repeat (ReadyCycles + 10) @(negedge clk);
    rd(dasf_pkg::DRIVE_STATE_FLAGS_ADDR, 16'h0021, "enable late");
    // addresses outside the two registers
    rd(16'h0002, 16'h0000, "unmapped low");
    rd(16'hFFFF, 16'h0000, "unmapped high");
    results();
  end
endmodule : tb_drive_alarm_status_flags
